// ===== tb/scan_ctrl_model.sv
// Behavioural scan controller driving test clock, mode select and data in
`timescale 1ns/1ps
module scan_ctrl_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    logic dq;
    // Clock starts low and both lines start high; each frame ends with mode select low
    initial
    begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h1;
    end
    // One test clock period; data out is taken at the rising edge
    task automatic step(input logic ms, input logic di, output logic q);
        tms_o = ms;
        tdi_o = di;
        #62.5;
        tck_o = 1'h1;
        // Data out has no pull; a released line reads as the inverse
        q = tdo_oe_i ? tdo_i : ~tdo_i;
        #62.5;
        tck_o = 1'h0;
    endtask
    // Mode select held high to reach reset, then idle
    task automatic reset_tap();
        repeat (6) step(1'h1, 1'h1, dq);
        step(1'h0, 1'h1, dq);
    endtask
    // Selects IR or DR, shifts n bits LSB first, updates and idles
    task automatic scan(input logic ir, input int n, input logic [63:0] d,
        output logic [63:0] q);
        q = 64'h0;
        step(1'h1, 1'h1, dq);
        if (ir)
            step(1'h1, 1'h1, dq);
        step(1'h0, 1'h1, dq);
        step(1'h0, 1'h1, dq);
        for (int i = 0; i < n; i++)
            step(i == n - 1, d[i], q[i]);
        step(1'h1, 1'h1, dq);
        step(1'h0, 1'h1, dq);
    endtask
endmodule

// ===== tb/tap_decoder_monitor.sv
// Port-level assertions for the boundary-scan instruction decoder
`timescale 1ns/1ps
module tap_decoder_monitor #(
    parameter int NUM_OUT = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic [NUM_OUT-1:0] func_out_i,
    input wire logic func_oe_i,
    input wire logic [NUM_OUT-1:0] pin_out_o,
    input wire logic pin_oe_o,
    input wire logic extest_active_o,
    input wire logic highz_active_o,
    input wire tap_pkg::instr_t instr_o
);
    import tap_pkg::*;
    logic [2:0] ones_r;
    logic [2:0] ones_nxt;
    // Run of mode-select highs seen at test clock rises, saturating
    always_comb
        ones_nxt = tms_i ? ones_r + {2'h0, ones_r != 3'h7} : 3'h0;
    always_ff @(posedge tck_i or posedge rst_i)
        if (rst_i)
            ones_r <= 3'h0;
        else
            ones_r <= ones_nxt;
    // Test clock side
    chk_reset_idcode: assert property (@(posedge tck_i) disable iff (rst_i)
        ones_r >= 3'h5 |-> instr_o == INSTR_IDCODE && !tdo_oe_o)
        else $error("identification not active after mode-select reset");
    chk_oe_in_shift: assert property (@(posedge tck_i) disable iff (rst_i)
        tdo_oe_o |-> !$past(tms_i) && !$past(tms_i, 2))
        else $error("data out driven outside a shift state");
    chk_instr_at_update: assert property (@(posedge tck_i) disable iff (rst_i)
        $changed(instr_o) |-> $past(tms_i) && $past(tms_i, 2))
        else $error("instruction changed outside update or reset");
    // System clock side
    chk_tdo_fall_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tck_i && $past(tck_i) |-> $stable(tdo_o) && $stable(tdo_oe_o))
        else $error("data out moved while test clock high");
    chk_extest_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (instr_o == INSTR_EXTEST) [*8] |-> extest_active_o)
        else $error("external test flag missing");
    chk_extest_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        extest_active_o [*3] |-> pin_oe_o)
        else $error("outputs not driven in external test");
    chk_highz_code: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $rose(highz_active_o) |-> instr_o == INSTR_SAMPLE_Z)
        else $error("float flag without its code");
    chk_highz_float: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        highz_active_o [*3] |-> !pin_oe_o)
        else $error("outputs driven while floated");
    chk_func_path: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!extest_active_o && !highz_active_o) [*3]
        |-> pin_out_o == $past(func_out_i) && pin_oe_o == $past(func_oe_i))
        else $error("functional outputs not passed through");
endmodule

// ===== tb/tap_instr_decoder_tb_top.sv
// Self-checking bench for the boundary-scan instruction decoder
`timescale 1ns/1ps
module tap_instr_decoder_tb_top;
    import tap_pkg::*;
    localparam int BSR_LEN = 18; // Eight inputs, eight outputs, two fixed cells
    logic clk_sys_i = 1'h0;
    logic rst_i = 1'h1;
    logic tck_i;
    logic tms_i;
    logic tdi_i;
    logic tdo_o;
    logic tdo_oe_o;
    logic pin_oe_o;
    logic extest_active_o;
    logic highz_active_o;
    logic spare;
    logic func_oe_i = 1'h0;
    logic [7:0] pin_in_i = 8'h00;
    logic [7:0] func_out_i = 8'h00;
    logic [7:0] pin_out_o;
    logic [7:0] upd = 8'h00;
    logic [7:0] bsr_out = 8'h00;
    instr_t instr_o;
    logic [31:0] seed = 32'h0000_CA45;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    tap_instr_decoder u_tap_instr_decoder (
        .clk_sys_i, .rst_i, .tck_i, .tms_i, .tdi_i, .tdo_o, .tdo_oe_o, .pin_in_i,
        .func_out_i, .func_oe_i, .pin_out_o, .pin_oe_o, .extest_active_o,
        .highz_active_o, .instr_o
    );
    scan_ctrl_model u_scan_ctrl_model (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
        .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o));

    always #12.5 clk_sys_i = ~clk_sys_i;

    // Cuts a hang short
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        comparisons = comparisons + 1;
        if (seen !== want)
        begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Fresh pad and core levels, held steady across the next capture
    task automatic new_pins();
        @(posedge clk_sys_i);
        pin_in_i <= 8'(rnd());
        func_out_i <= 8'(rnd());
        func_oe_i <= 1'(rnd());
        @(posedge clk_sys_i);
    endtask

    // Pin side once the mode flags have crossed over
    task automatic check_pins(input instr_t c);
        logic ext;
        logic oe;
        ext = c == INSTR_EXTEST;
        oe = ext || (c != INSTR_SAMPLE_Z && func_oe_i);
        repeat (6) @(posedge clk_sys_i);
        #1;
        check({tdo_oe_o, extest_active_o, highz_active_o, pin_oe_o, pin_out_o},
            {1'h0, ext, c == INSTR_SAMPLE_Z, oe, ext ? upd : func_out_i});
    endtask

    // Data scan of 64 bits: captured bits first, then the bits fed in
    task automatic scan_dr(input instr_t c);
        logic [63:0] d;
        logic [63:0] q;
        logic [63:0] cap;
        int len;
        logic bsr;
        bsr = c == INSTR_EXTEST || c == INSTR_SAMPLE_Z || c == INSTR_SAMPLE_PRELOAD;
        len = c == INSTR_IDCODE ? 32 : bsr ? BSR_LEN : 1;
        cap = c == INSTR_IDCODE ? 64'(ID_VALUE) : 64'(BYPASS_CAPTURE_VALUE);
        if (bsr)
            cap = {46'h0, {2{FIXED_CELL_VALUE}}, c == INSTR_EXTEST ? upd : func_out_i, pin_in_i};
        d = {rnd(), rnd()};
        u_scan_ctrl_model.scan(1'h0, 64, d, q);
        check(q, (d << len) | cap);
        if (bsr)
            bsr_out = d[54 +: 8];
        if (c == INSTR_EXTEST || c == INSTR_SAMPLE_PRELOAD)
            upd = bsr_out;
        check_pins(c);
    endtask

    // Loads one instruction, then checks its pins and data path
    task automatic run_code(input instr_t c);
        logic [63:0] q;
        new_pins();
        u_scan_ctrl_model.scan(1'h1, 3, 64'(c), q);
        check(q[2:0], IR_CAPTURE_PATTERN);
        check(instr_o, c);
        if (c == INSTR_EXTEST)
            upd = bsr_out;
        check_pins(c);
        scan_dr(c);
    endtask

    initial
    begin
        repeat (2) u_scan_ctrl_model.step(1'h1, 1'h1, spare);
        @(posedge clk_sys_i);
        rst_i <= 1'h0;
        @(posedge clk_sys_i);
        check(instr_o, INSTR_IDCODE);
        // Power-up leaves the port in its reset state; one low step reaches idle
        u_scan_ctrl_model.step(1'h0, 1'h1, spare);
        scan_dr(INSTR_IDCODE);
        for (int i = 7; i >= 0; i--)
            run_code(3'(i));
        repeat (8) run_code(3'(rnd()));
        u_scan_ctrl_model.reset_tap();
        check(instr_o, INSTR_IDCODE);
        scan_dr(INSTR_IDCODE);
        tally_and_finish();
    end
endmodule

bind tap_instr_decoder tap_decoder_monitor #(.NUM_OUT(NUM_OUT)) u_tap_decoder_monitor (
    .clk_sys_i, .rst_i, .tck_i, .tms_i, .tdo_o, .tdo_oe_o, .func_out_i, .func_oe_i,
    .pin_out_o, .pin_oe_o, .extest_active_o, .highz_active_o, .instr_o
);

// ===== verilog/bit_sync.sv
// Two flip-flop level synchroniser, parameterised width
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    import tap_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_st_t;

    sync_st_t st_r;
    sync_st_t st_nxt;

    // First stage feeds only the second stage
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end

    // Stage registers
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= {(2 * W){SYNC_RESET_VALUE}};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.s2;

endmodule

// ===== verilog/tap_fsm.sv
// Test access port controller state machine on the test clock
`timescale 1ns/1ps
module tap_fsm (
    input wire logic tck_i,
    input wire logic rst_i,
    input wire logic tms_i,
    output tap_pkg::tap_state_t state_o
);
    import tap_pkg::*;

    typedef struct packed {
        tap_state_t st;
    } fsm_st_t;

    fsm_st_t st_r;
    fsm_st_t st_nxt;

    // Next state from test mode select; five highs reach reset from anywhere
    always_comb
    begin
        st_nxt = st_r;
        case (st_r.st)
            ST_RESET:    st_nxt.st = tms_i ? ST_RESET : ST_IDLE;
            ST_IDLE:     st_nxt.st = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR:   st_nxt.st = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR:   st_nxt.st = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: st_nxt.st = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: st_nxt.st = tms_i ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: st_nxt.st = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: st_nxt.st = tms_i ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR:   st_nxt.st = tms_i ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR:   st_nxt.st = tms_i ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR:   st_nxt.st = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: st_nxt.st = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: st_nxt.st = tms_i ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: st_nxt.st = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: st_nxt.st = tms_i ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR:   st_nxt.st = tms_i ? ST_SEL_DR : ST_IDLE;
            default:     st_nxt.st = ST_RESET;
        endcase
    end

    // Power-up reset puts the controller in its reset state
    always_ff @(posedge tck_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= '{st: ST_RESET};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign state_o = st_r.st;

endmodule

// ===== verilog/tap_instr_decoder.sv
// Boundary-scan instruction register, decode and serial data registers
// How it works
// - Capture-IR loads 01 into low IR bits
// - Shift-IR puts IR between TDI and TDO
// - New instruction takes effect only at Update-IR
// - Code 111 selects the one-bit bypass register
// - Code 100 captures pins, shifts boundary register
// - Pinless boundary cells capture their fixed default
// - Code 000 selects external test, boundary path
// - External test never blocks functional inputs
// - External test drives outputs at Update-IR fall
// - External test Capture-DR loads pins and defaults
// - External test: outputs follow their boundary cells
// - Code 001 captures 32-bit identification value
// - Identification code loaded at power-up and reset
// - Code 010 floats outputs, boundary register path
// - Codes read binary, MSB on the left
// - Instruction register is three bits wide
// - Identification bit 0 reaches TDO first
// - Five TMS highs or power-up reset the port
// - Shift on rising edge, TDO on falling edge
`timescale 1ns/1ps
module tap_instr_decoder #(
    parameter int NUM_IN = 8,
    parameter int NUM_OUT = 8,
    parameter int NUM_FIXED = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic [NUM_IN-1:0] pin_in_i,
    input wire logic [NUM_OUT-1:0] func_out_i,
    input wire logic func_oe_i,
    output logic [NUM_OUT-1:0] pin_out_o,
    output logic pin_oe_o,
    output logic extest_active_o,
    output logic highz_active_o,
    output tap_pkg::instr_t instr_o
);
    import tap_pkg::*;

    localparam int BSR_W = NUM_IN + NUM_OUT + NUM_FIXED;
    localparam int RING_W = NUM_IN + NUM_OUT;

    // True for codes that route the boundary register between TDI and TDO
    function automatic logic uses_bsr(input instr_t code);
        uses_bsr = (code == INSTR_EXTEST) || (code == INSTR_SAMPLE_Z) ||
                   (code == INSTR_SAMPLE_PRELOAD);
    endfunction

    // True for codes that load the output update stage
    function automatic logic loads_update(input instr_t code);
        loads_update = (code == INSTR_EXTEST) || (code == INSTR_SAMPLE_PRELOAD);
    endfunction

    // Rising-edge test clock state: shift registers
    typedef struct packed {
        instr_t ir_sh;
        logic [BSR_W-1:0] bsr;
        logic [ID_W-1:0] idr;
        logic byp;
    } rise_st_t;

    // Falling-edge test clock state: active instruction, output stage, TDO
    typedef struct packed {
        instr_t instr;
        logic [NUM_OUT-1:0] upd;
        logic tog;
        logic tdo;
        logic tdo_oe;
    } fall_st_t;

    // System clock state: pin drive side
    typedef struct packed {
        logic tog_seen;
        logic ext;
        logic hiz;
        logic [NUM_OUT-1:0] drive;
        logic [NUM_OUT-1:0] out;
        logic oe;
    } sys_st_t;

    rise_st_t rise_r;
    rise_st_t rise_nxt;
    fall_st_t fall_r;
    fall_st_t fall_nxt;
    sys_st_t sys_r;
    sys_st_t sys_nxt;
    tap_state_t state;
    logic [RING_W-1:0] ring_sync;
    logic [2:0] mode_sync;
    logic ext_code;
    logic hiz_code;

    // Controller state machine on the test clock
    tap_fsm u_fsm (
        .tck_i(tck_i),
        .rst_i(rst_i),
        .tms_i(tms_i),
        .state_o(state)
    );

    // Pin ring levels come from another domain; two flops before capture
    bit_sync #(.W(RING_W)) u_ring_sync (
        .clk_i(tck_i),
        .rst_i(rst_i),
        .d_i({sys_r.out, pin_in_i}),
        .q_o(ring_sync)
    );

    // Mode levels and update toggle cross into the system domain
    assign ext_code = (fall_r.instr == INSTR_EXTEST);
    assign hiz_code = (fall_r.instr == INSTR_SAMPLE_Z);

    bit_sync #(.W(3)) u_mode_sync (
        .clk_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i({fall_r.tog, hiz_code, ext_code}),
        .q_o(mode_sync)
    );

    // Capture and shift on the rising test clock edge
    always_comb
    begin
        rise_nxt = rise_r;
        case (state)
            ST_RESET:
            begin
                rise_nxt.ir_sh = INSTR_IDCODE;
            end
            ST_CAP_IR:
            begin
                rise_nxt.ir_sh = IR_CAPTURE_PATTERN;
            end
            ST_SHIFT_IR:
            begin
                rise_nxt.ir_sh = {tdi_i, rise_r.ir_sh[IR_W-1:1]};
            end
            ST_CAP_DR:
            begin
                if (uses_bsr(fall_r.instr))
                begin
                    // Inputs, output ring, then fixed cells
                    rise_nxt.bsr = {{NUM_FIXED{FIXED_CELL_VALUE}}, ring_sync};
                end
                if (fall_r.instr == INSTR_IDCODE)
                begin
                    rise_nxt.idr = ID_VALUE;
                end
                rise_nxt.byp = BYPASS_CAPTURE_VALUE;
            end
            ST_SHIFT_DR:
            begin
                if (uses_bsr(fall_r.instr))
                begin
                    rise_nxt.bsr = {tdi_i, rise_r.bsr[BSR_W-1:1]};
                end
                else if (fall_r.instr == INSTR_IDCODE)
                begin
                    rise_nxt.idr = {tdi_i, rise_r.idr[ID_W-1:1]};
                end
                else
                begin
                    rise_nxt.byp = tdi_i;
                end
            end
            default:
            begin
                rise_nxt = rise_r;
            end
        endcase
    end

    always_ff @(posedge tck_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rise_r <= '{ir_sh: INSTR_IDCODE, bsr: '0, idr: '0, byp: BYPASS_CAPTURE_VALUE};
        end
        else
        begin
            rise_r <= rise_nxt;
        end
    end

    // Instruction update, output stage and TDO on the falling test clock edge
    always_comb
    begin
        fall_nxt = fall_r;
        fall_nxt.tdo_oe = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
        case (state)
            ST_RESET:
            begin
                fall_nxt.instr = INSTR_IDCODE;
            end
            ST_SHIFT_IR:
            begin
                fall_nxt.tdo = rise_r.ir_sh[0];
            end
            ST_SHIFT_DR:
            begin
                if (uses_bsr(fall_r.instr))
                begin
                    fall_nxt.tdo = rise_r.bsr[0];
                end
                else if (fall_r.instr == INSTR_IDCODE)
                begin
                    fall_nxt.tdo = rise_r.idr[0];
                end
                else
                begin
                    fall_nxt.tdo = rise_r.byp;
                end
            end
            ST_UPD_IR:
            begin
                fall_nxt.instr = rise_r.ir_sh;
                if (rise_r.ir_sh == INSTR_EXTEST)
                begin
                    // Entering external test drives the boundary contents
                    fall_nxt.upd = rise_r.bsr[NUM_IN +: NUM_OUT];
                    fall_nxt.tog = ~fall_r.tog;
                end
            end
            ST_UPD_DR:
            begin
                if (loads_update(fall_r.instr))
                begin
                    fall_nxt.upd = rise_r.bsr[NUM_IN +: NUM_OUT];
                    fall_nxt.tog = ~fall_r.tog;
                end
            end
            default:
            begin
                fall_nxt.tdo = fall_r.tdo;
            end
        endcase
    end

    always_ff @(negedge tck_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fall_r <= '{instr: INSTR_IDCODE, upd: '0, tog: 1'h0, tdo: 1'h0, tdo_oe: 1'h0};
        end
        else
        begin
            fall_r <= fall_nxt;
        end
    end

    // Pin drive in the system domain; the update word is stable when the toggle lands
    always_comb
    begin
        sys_nxt = sys_r;
        sys_nxt.tog_seen = mode_sync[2];
        sys_nxt.ext = mode_sync[0];
        sys_nxt.hiz = mode_sync[1];
        if (mode_sync[2] != sys_r.tog_seen)
        begin
            sys_nxt.drive = fall_r.upd;
        end
        if (mode_sync[0])
        begin
            sys_nxt.out = sys_nxt.drive;
            sys_nxt.oe = 1'h1;
        end
        else
        begin
            sys_nxt.out = func_out_i;
            sys_nxt.oe = func_oe_i;
        end
        if (mode_sync[1])
        begin
            sys_nxt.oe = 1'h0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sys_r <= '0;
        end
        else
        begin
            sys_r <= sys_nxt;
        end
    end

    // Functional inputs are only observed, never gated
    assign pin_out_o = sys_r.out;
    assign pin_oe_o = sys_r.oe;
    assign extest_active_o = sys_r.ext;
    assign highz_active_o = sys_r.hiz;
    assign tdo_o = fall_r.tdo;
    assign tdo_oe_o = fall_r.tdo_oe;
    assign instr_o = fall_r.instr;

endmodule

// ===== verilog/tap_pkg.sv
// Shared constants and types for the boundary-scan instruction logic
package tap_pkg;

    // Instruction register width and codes, MSB on the left
    localparam int IR_W = 3;
    typedef logic [IR_W-1:0] instr_t;
    localparam instr_t INSTR_EXTEST = 3'h0;
    localparam instr_t INSTR_IDCODE = 3'h1;
    localparam instr_t INSTR_SAMPLE_Z = 3'h2;
    localparam instr_t INSTR_PRIV_A = 3'h3;
    localparam instr_t INSTR_SAMPLE_PRELOAD = 3'h4;
    localparam instr_t INSTR_PRIV_B = 3'h5;
    localparam instr_t INSTR_PRIV_C = 3'h6;
    localparam instr_t INSTR_BYPASS = 3'h7;

    // Pattern loaded in Capture-IR (low two bits 01)
    localparam instr_t IR_CAPTURE_PATTERN = 3'h1;

    // Identification register
    localparam int ID_W = 32;
    // Arbitrary neutral identification value; bit 0 set as the scan standard asks
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0A5B;

    // Value of boundary cells with no pin, and of the bypass cell on capture
    localparam logic FIXED_CELL_VALUE = 1'h1;
    localparam logic BYPASS_CAPTURE_VALUE = 1'h0;

    // Synchroniser reset level
    localparam logic SYNC_RESET_VALUE = 1'h0;

    // Test access port controller states
    typedef enum logic [3:0] {
        ST_RESET     = 4'h0,
        ST_IDLE      = 4'h1,
        ST_SEL_DR    = 4'h2,
        ST_CAP_DR    = 4'h3,
        ST_SHIFT_DR  = 4'h4,
        ST_EXIT1_DR  = 4'h5,
        ST_PAUSE_DR  = 4'h6,
        ST_EXIT2_DR  = 4'h7,
        ST_UPD_DR    = 4'h8,
        ST_SEL_IR    = 4'h9,
        ST_CAP_IR    = 4'hA,
        ST_SHIFT_IR  = 4'hB,
        ST_EXIT1_IR  = 4'hC,
        ST_PAUSE_IR  = 4'hD,
        ST_EXIT2_IR  = 4'hE,
        ST_UPD_IR    = 4'hF
    } tap_state_t;

endpackage
